// file: include/tic_pkg.sv
// shared constants and types for the time interval counter
package tic_pkg;
  localparam int unsigned CORE_HZ       = 40_000_000;
  localparam int unsigned XTAL_HZ       = 32_768;
  localparam int unsigned FRAC_HZ       = 128;
  localparam int unsigned XTAL_DIV      = CORE_HZ / XTAL_HZ;
  localparam int unsigned PRESC_DIV     = XTAL_HZ / FRAC_HZ;
  localparam int unsigned CLR_HOLD_NS_X10 = 305;
  localparam int unsigned CLR_HOLD_CYC  = (CLR_HOLD_NS_X10 * 100 + 24) / 25;

  localparam logic [7:0] ADDR_CTRL      = 8'hA1;
  localparam logic [7:0] ADDR_FRAC      = 8'hA2;
  localparam logic [7:0] ADDR_SEC       = 8'hA3;
  localparam logic [7:0] ADDR_MIN       = 8'hA4;
  localparam logic [7:0] ADDR_HOUR      = 8'hA5;
  localparam logic [7:0] ADDR_CMP       = 8'hA6;

  localparam int unsigned BIT_TIMEBASE_CLOCK_ENABLE      = 0;
  localparam int unsigned BIT_RUN       = 1;
  localparam int unsigned BIT_FLAG      = 2;
  localparam int unsigned BIT_ONESHOT   = 3;
  localparam int unsigned BIT_BASE_LO   = 4;
  localparam int unsigned BIT_RSV6      = 6;

  localparam logic [7:0] FRAC_MAX       = 8'h7F;
  localparam logic [7:0] SEC_MAX        = 8'h3B;
  localparam logic [7:0] MIN_MAX        = 8'h3B;
  localparam logic [7:0] HOUR_MAX       = 8'h17;
  localparam logic [7:0] ZERO8          = 8'h00;

  typedef enum logic [1:0] {
    BASE_FRAC,
    BASE_SEC,
    BASE_MIN,
    BASE_HOUR
  } tic_base_e;
endpackage

// file: include/tic_tick_if.sv
// timebase overflow strobes passed to the interval counter
`timescale 1ns/1ps
interface tic_tick_if;
  logic [3:0] wrap;
  modport src (output wrap);
  modport dst (input wrap);
endinterface

// file: design/tic_interval.sv
// 8-bit interval counter with compare, one-shot and auto-reload
`timescale 1ns/1ps
module tic_interval
  import tic_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  tic_tick_if.dst         tick,
  input  wire logic       run,
  input  wire logic       run_hold_ok,
  input  wire logic [1:0] base_sel,
  input  wire logic       one_shot,
  input  wire logic [7:0] compare,
  output logic            match,
  output logic [7:0]      count
);
  typedef struct packed {
    logic [7:0] cnt;
  } tic_iv_s;

  tic_iv_s st_r;
  tic_iv_s st_nxt;
  logic    step;

  always_comb begin
    st_nxt = st_r;
    step   = tick.wrap[base_sel];
    match  = 1'b0;
    if (!run) begin
      if (run_hold_ok) begin
        st_nxt.cnt = ZERO8;
      end
    end else if (step) begin
      if (st_r.cnt + 8'h01 == compare) begin
        match = 1'b1;
        st_nxt.cnt = ZERO8;
      end else begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
    end
    count = st_r.cnt;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// file: design/tic_top.sv
// time interval counter: timebase cascade, control and register port
`timescale 1ns/1ps
module tic_top
  import tic_pkg::*;
#(
  parameter int unsigned XTAL_DIV_P  = XTAL_DIV,
  parameter int unsigned PRESC_DIV_P = PRESC_DIV
) (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       por,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic [7:0]      sfr_rdata,
  input  wire logic       int_enable,
  output logic            int_req,
  output logic [7:0]      interval_count
);
  typedef struct packed {
    logic [15:0] xdiv;
    logic [15:0] presc;
    logic [7:0]  frac;
    logic [7:0]  sec;
    logic [7:0]  mins;
    logic [7:0]  hour;
    logic [7:0]  cmp;
    logic        timebase_clock_enable;
    logic        run;
    logic        flag;
    logic        one_shot;
    logic [1:0]  base_sel;
    logic        rsv7;
    logic        rsv6;
    logic [15:0] timebase_clock_enable_low;
    logic [15:0] run_low;
    logic [7:0]  rdata;
  } tic_top_s;

  tic_top_s   st_r;
  tic_top_s   st_nxt;
  tic_tick_if tick ();
  logic       match;
  logic [7:0] ivl_count;
  logic       tick128;
  logic       timebase_clock_enable_hold_ok;
  logic       timebase_clock_enable_clr;
  logic       run_hold_ok;
  logic [7:0] ctrl_val;

  function automatic logic [7:0] inc_wrap(input logic [7:0] v, input logic [7:0] max);
    inc_wrap = (v == max) ? ZERO8 : v + 8'h01;
  endfunction

  tic_interval u_ivl (
    .core_clk    (core_clk),
    // power-on must park the interval counter at once, not after the hold time
    .srst        (srst || por),
    .tick        (tick),
    .run         (st_r.run),
    .run_hold_ok (run_hold_ok),
    .base_sel    (st_r.base_sel),
    .one_shot    (st_r.one_shot),
    .compare     (st_r.cmp),
    .match       (match),
    .count       (ivl_count)
  );

  // clear takes effect only after enable held low for one crystal period
  assign timebase_clock_enable_hold_ok = (st_r.timebase_clock_enable_low >= 16'(CLR_HOLD_CYC));
  assign run_hold_ok  = (st_r.run_low >= 16'(CLR_HOLD_CYC));
  // single clear pulse, so time written while stopped is not wiped again;
  // a write inside the first hold period can still be lost to that pulse
  assign timebase_clock_enable_clr     = !st_r.timebase_clock_enable && (st_r.timebase_clock_enable_low == 16'(CLR_HOLD_CYC - 1));
  assign tick128 = st_r.timebase_clock_enable && (st_r.xdiv == 16'(XTAL_DIV_P - 1))
                   && (st_r.presc == 16'(PRESC_DIV_P - 1));

  always_comb begin
    ctrl_val = {st_r.rsv7, st_r.rsv6, st_r.base_sel, st_r.one_shot,
                st_r.flag, st_r.run, st_r.timebase_clock_enable};
    tick.wrap[0] = tick128;
    tick.wrap[1] = tick128 && st_r.frac == FRAC_MAX;
    tick.wrap[2] = tick.wrap[1] && st_r.sec == SEC_MAX;
    tick.wrap[3] = tick.wrap[2] && st_r.mins == MIN_MAX;
    st_nxt = st_r;
    st_nxt.timebase_clock_enable_low = (st_r.timebase_clock_enable || timebase_clock_enable_hold_ok) ? st_r.timebase_clock_enable_low : st_r.timebase_clock_enable_low + 16'h0001;
    if (st_r.timebase_clock_enable) st_nxt.timebase_clock_enable_low = 16'h0000;
    st_nxt.run_low = st_r.run ? 16'h0000
                   : (run_hold_ok ? st_r.run_low : st_r.run_low + 16'h0001);
    if (st_r.timebase_clock_enable) begin
      // crystal rate is emulated by a core-clock divider
      st_nxt.xdiv = (st_r.xdiv == 16'(XTAL_DIV_P - 1)) ? 16'h0000 : st_r.xdiv + 16'h0001;
      if (st_r.xdiv == 16'(XTAL_DIV_P - 1)) begin
        st_nxt.presc = (st_r.presc == 16'(PRESC_DIV_P - 1)) ? 16'h0000
                       : st_r.presc + 16'h0001;
      end
      if (tick.wrap[0]) st_nxt.frac = inc_wrap(st_r.frac, FRAC_MAX);
      if (tick.wrap[1]) st_nxt.sec  = inc_wrap(st_r.sec, SEC_MAX);
      if (tick.wrap[2]) st_nxt.mins = inc_wrap(st_r.mins, MIN_MAX);
      if (tick.wrap[3]) st_nxt.hour = inc_wrap(st_r.hour, HOUR_MAX);
    end else if (timebase_clock_enable_clr) begin
      st_nxt.xdiv  = 16'h0000;
      st_nxt.presc = 16'h0000;
      st_nxt.frac  = ZERO8;
      st_nxt.sec   = ZERO8;
      st_nxt.mins  = ZERO8;
      st_nxt.hour  = ZERO8;
    end
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_CTRL: begin
          st_nxt.timebase_clock_enable     = sfr_wdata[BIT_TIMEBASE_CLOCK_ENABLE];
          st_nxt.run      = sfr_wdata[BIT_RUN];
          st_nxt.flag     = sfr_wdata[BIT_FLAG];
          st_nxt.one_shot = sfr_wdata[BIT_ONESHOT];
          st_nxt.base_sel = sfr_wdata[BIT_BASE_LO +: 2];
          st_nxt.rsv6     = sfr_wdata[BIT_RSV6];
          st_nxt.rsv7     = sfr_wdata[BIT_RSV6 + 1];
        end
        ADDR_FRAC: if (!st_r.timebase_clock_enable) st_nxt.frac = sfr_wdata;
        ADDR_SEC:  if (!st_r.timebase_clock_enable) st_nxt.sec  = sfr_wdata;
        ADDR_MIN:  if (!st_r.timebase_clock_enable) st_nxt.mins = sfr_wdata;
        ADDR_HOUR: if (!st_r.timebase_clock_enable) st_nxt.hour = sfr_wdata;
        ADDR_CMP:  st_nxt.cmp = sfr_wdata;
        default: ;
      endcase
    end
    // hardware set beats a same-cycle software clear
    if (match && st_r.run) begin
      st_nxt.flag = 1'b1;
      if (st_r.one_shot) st_nxt.run = 1'b0;
    end
    unique case (sfr_addr)
      ADDR_CTRL: st_nxt.rdata = ctrl_val;
      ADDR_FRAC: st_nxt.rdata = st_r.frac;
      ADDR_SEC:  st_nxt.rdata = st_r.sec;
      ADDR_MIN:  st_nxt.rdata = st_r.mins;
      ADDR_HOUR: st_nxt.rdata = st_r.hour;
      ADDR_CMP:  st_nxt.rdata = st_r.cmp;
      default:   st_nxt.rdata = ZERO8;
    endcase
    if (!sfr_rd) st_nxt.rdata = st_r.rdata;
  end

  always_ff @(posedge core_clk) begin
    if (por) begin
      st_r <= '0;
    end else if (srst) begin
      st_r.cmp      <= ZERO8;
      st_r.run      <= 1'b0;
      st_r.flag     <= 1'b0;
      st_r.one_shot <= 1'b0;
      st_r.base_sel <= 2'b00;
      st_r.rsv6     <= 1'b0;
      st_r.rsv7     <= 1'b0;
      st_r.run_low  <= 16'h0000;
      st_r.timebase_clock_enable_low <= 16'h0000;
      st_r.rdata    <= ZERO8;
      st_r.xdiv     <= st_r.xdiv;
      st_r.presc    <= st_r.presc;
      if (!st_r.timebase_clock_enable) begin
        st_r.frac <= ZERO8;
        st_r.sec  <= ZERO8;
        st_r.mins <= ZERO8;
        st_r.hour <= ZERO8;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign int_req        = st_r.flag && int_enable;
  assign sfr_rdata      = st_r.rdata;
  assign interval_count = ivl_count;
endmodule

// file: tb/tic_top_props.sv
// port assertions for the time interval counter
`timescale 1ns/1ps
module tic_top_props
  import tic_pkg::*;
#(
  parameter int unsigned XTAL_DIV_P  = XTAL_DIV,
  parameter int unsigned PRESC_DIV_P = PRESC_DIV
) (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       por,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       int_enable,
  input wire logic       int_req,
  input wire logic [7:0] interval_count
);
  logic unmapped;
  assign unmapped = (sfr_addr < ADDR_CTRL) || (sfr_addr > ADDR_CMP);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst || por);
  a_req_needs_en: assert property (int_req |-> int_enable) else $error("bad req");
  a_count_step: assert property (!$stable(interval_count) |->
    interval_count == $past(interval_count) + 8'h01 || interval_count == ZERO8)
    else $error("bad step");
  a_match_zeroes: assert property ($rose(int_req) && $past(int_enable) |->
    interval_count == ZERO8) else $error("no reload");
  a_flag_sticky: assert property (int_req && !(sfr_wr && sfr_addr == ADDR_CTRL) |=>
    int_req || !int_enable) else $error("flag lost");
  a_por_clears: assert property (disable iff (1'b0) por |=>
    interval_count == ZERO8 && sfr_rdata == ZERO8) else $error("por");
  a_srst_rdata: assert property (disable iff (por) srst |=> sfr_rdata == ZERO8)
    else $error("srst");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("rdata");
  a_cmp_readback: assert property (sfr_wr && sfr_addr == ADDR_CMP ##1 !sfr_wr ##1
    sfr_rd && !sfr_wr && sfr_addr == ADDR_CMP |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("readback");
  a_unmapped_zero: assert property (sfr_rd && unmapped |=> sfr_rdata == ZERO8)
    else $error("unmapped");
  cover property ($rose(int_req));
  cover property (sfr_rd && unmapped);
  cover property (interval_count != ZERO8 ##1 interval_count == ZERO8);
endmodule
bind tic_top tic_top_props #(.XTAL_DIV_P(XTAL_DIV_P), .PRESC_DIV_P(PRESC_DIV_P)) i_props (
  .core_clk(core_clk), .srst(srst), .por(por), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .int_enable(int_enable),
  .int_req(int_req), .interval_count(interval_count));

// file: tb/time_interval_counter_test.sv
// self-checking bench for the time interval counter
`timescale 1ns/1ps
module time_interval_counter_test;
  import tic_pkg::*;
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic       por = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_rd = 1'b0;
  logic       int_enable = 1'b1;
  logic [7:0] sfr_rdata;
  logic       int_req;
  logic [7:0] interval_count;
  logic [7:0] c;
  int         mismatches = 0;
  int         n_checks = 0;
  time        t0;
  always #12.5 core_clk = ~core_clk;
  tic_top #(.XTAL_DIV_P(2), .PRESC_DIV_P(2)) i_dut (
    .core_clk(core_clk), .srst(srst), .por(por), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .int_enable(int_enable),
    .int_req(int_req), .interval_count(interval_count));
  // a fraction step is two crystal ticks of two core cycles
  function automatic logic [7:0] period(logic [7:0] n);
    return n * 8'h04;
  endfunction
  // only the fraction base sees a second overflow within the wait
  function automatic logic [7:0] after_wait(int b);
    return (b == 0) ? ZERO8 : 8'h01;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(string w, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rc(string w, logic [7:0] a, logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    cyc(1);
    chk(w, e, sfr_rdata);
  endtask
  task automatic pulse(bit p);
    if (p) por = 1'b1; else srst = 1'b1;
    cyc(2);
    por = 1'b0;
    srst = 1'b0;
  endtask
  task automatic preset();
    wr(ADDR_HOUR, HOUR_MAX);
    wr(ADDR_MIN, MIN_MAX);
    wr(ADDR_SEC, SEC_MAX);
    wr(ADDR_FRAC, FRAC_MAX);
  endtask
  task automatic wait_req();
    for (int i = 0; i < 2000 && int_req !== 1'b1; i++) begin
      cyc(1);
    end
    if (int_req !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  initial begin
    void'($urandom(84327));
    cyc(14);
    pulse(1'b1);
    for (int a = 1; a <= 6; a++) begin
      rc("reset", ADDR_CTRL + 8'(a - 1), ZERO8);
    end
    rc("unmapped", 8'hA0, ZERO8);
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      wr(ADDR_CMP, c);
      rc("compare", ADDR_CMP, c);
    end
    preset();
    rc("hour set", ADDR_HOUR, HOUR_MAX);
    wr(ADDR_CTRL, 8'h41);
    wr(ADDR_SEC, 8'h05);
    cyc(8);
    rc("sec", ADDR_SEC, ZERO8);
    rc("min", ADDR_MIN, ZERO8);
    rc("hour", ADDR_HOUR, ZERO8);
    pulse(1'b1);
    wr(ADDR_MIN, 8'h2A);
    wr(ADDR_CTRL, 8'h41);
    pulse(1'b0);
    rc("kept min", ADDR_MIN, 8'h2A);
    rc("kept ctrl", ADDR_CTRL, 8'h01);
    wr(ADDR_CTRL, ZERO8);
    cyc(1300);
    rc("cleared min", ADDR_MIN, ZERO8);
    wr(ADDR_MIN, 8'h2A);
    pulse(1'b0);
    rc("srst min", ADDR_MIN, ZERO8);
    for (int b = 0; b < 4; b++) begin
      pulse(1'b1);
      preset();
      wr(ADDR_CMP, 8'h02);
      wr(ADDR_CTRL, 8'h4B | 8'(b << 4));
      cyc(24);
      chk("count", after_wait(b), interval_count);
      if (b == 0) begin
        rc("one shot", ADDR_CTRL, 8'h4D);
        chk("req", 8'h01, {7'h00, int_req});
        int_enable = 1'b0;
        cyc(1);
        chk("masked", ZERO8, {7'h00, int_req});
        int_enable = 1'b1;
        wr(ADDR_CTRL, 8'h49);
        chk("cleared", ZERO8, {7'h00, int_req});
      end
    end
    pulse(1'b1);
    c = 8'($urandom % 5) + 8'h02;
    wr(ADDR_CMP, c);
    wr(ADDR_CTRL, 8'h43);
    wait_req();
    t0 = $time;
    wr(ADDR_CTRL, 8'h43);
    wait_req();
    chk("reload", period(c), 8'(($time - t0) / 25));
    cyc(4);
    chk("running", 8'h01, interval_count);
    wr(ADDR_CTRL, 8'h41);
    cyc(1300);
    chk("stopped", ZERO8, interval_count);
    tally_and_finish();
  end
endmodule
